// >>> logic/hw_config_consts.svh
`ifndef HW_CONFIG_CONSTS_SVH
`define HW_CONFIG_CONSTS_SVH
// Functional notes
// - Watchdog reset allow bit (lower byte bit 3) lets the watchdog reset when 1, blocks it when 0; default 1.
// - Data flash size field (lower byte bits 2-0) picks the partition, 000 reserved, 111 none by default.
// - Digital brownout level (upper byte bits 7-6) selects 4.5/4.2/2.7/2.5 V for 00..11, default 11.
// - Analog brownout level (upper byte bits 5-4) uses the same encodings, default 11.
// - Analog brownout off bit (upper byte bit 3) enables analog brownout reset at 0, disables at 1 (default).
// - Digital brownout off bit (upper byte bit 2) enables digital brownout reset at 0, disables at 1 (default).
// - Port zero select 0 makes port 0 the external bus with P3.6/P3.7 as strobes; 1 (default) is GPIO.
// - Ports two/three select 0 makes port 2 the external bus with P3.6/P3.7 strobes; 1 (default) is GPIO.
// - The upper byte at index 7Eh is writable only in programming mode and always readable.
// - Configuration bits are nonvolatile and change only in programming mode, over the programming path or the 94h window.
// - The 128 bytes are reached via an index register at 93h and a data register at 94h.
// - The lower byte sits at index 7Fh with watchdog bit 3 and flash size bits 2-0.
`define SFR_CONFIG_INDEX     8'h93
`define SFR_CONFIG_WINDOW    8'h94
`define CFG_UPPER_INDEX      7'h7e
`define CFG_LOWER_INDEX      7'h7f
`define CFG_ERASED_BYTE      8'hff
`define INDEX_RESET          8'h00
`define WINDOW_RESET         8'h00
`define LOWER_WDOG_BIT       3
`define LOWER_DFS_MSB        2
`define UPPER_DBL_MSB        7
`define UPPER_DBL_LSB        6
`define UPPER_ABL_MSB        5
`define UPPER_ABL_LSB        4
`define UPPER_AOFF_BIT       3
`define UPPER_DOFF_BIT       2
`define UPPER_P0_BIT         1
`define UPPER_P23_BIT        0
`endif

// >>> logic/hw_config_pkg.sv
package hw_config_pkg;
  typedef enum logic [1:0] {
    level_4v5 = 2'b00,
    level_4v2 = 2'b01,
    level_2v7 = 2'b10,
    level_2v5 = 2'b11
  } brownout_level_t;

  typedef enum logic [2:0] {
    dflash_reserved = 3'b000,
    dflash_32k      = 3'b001,
    dflash_16k      = 3'b010,
    dflash_8k       = 3'b011,
    dflash_4k       = 3'b100,
    dflash_2k       = 3'b101,
    dflash_1k       = 3'b110,
    dflash_none     = 3'b111
  } dflash_size_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } sfr_req_t;

  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [7:0]  wdata;
  } prog_req_t;

  typedef struct packed {
    logic            watchdog_reset_allow;
    dflash_size_t    data_flash_size_sel;
    logic            data_flash_reserved;
    brownout_level_t digital_brownout_level;
    brownout_level_t analog_brownout_level;
    logic            analog_brownout_reset_en;
    logic            digital_brownout_reset_en;
    logic            port_zero_ext_bus;
    logic            port_two_ext_bus;
    logic            p36_p37_strobes;
  } hw_ctrl_t;

  typedef struct packed {
    logic [7:0] config_byte_index_reg;
    logic [7:0] config_byte_window_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    hw_ctrl_t   ctrl_reg;
  } bank_state_t;
endpackage

// >>> logic/hw_config_byte_bank.sv
`include "hw_config_consts.svh"

module hw_config_byte_bank
  import hw_config_pkg::*;
#(
  parameter int NUM_BYTES = 128
)
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_b,
  // Mode
  input  wire logic     user_application_mode,
  // Core special-function register access
  input  wire sfr_req_t sfr_req,
  output logic [7:0]    sfr_rdata,
  output logic          sfr_rvalid,
  // Serial or parallel programming path
  input  wire prog_req_t prog_req,
  // Decoded configuration controls
  output hw_ctrl_t      hw_ctrl
);

  // Nonvolatile array: survives reset and starts out as erased flash
  logic [7:0]  cfg_mem [NUM_BYTES] = '{default: `CFG_ERASED_BYTE};

  // Registered state and its next value
  bank_state_t st_reg;
  bank_state_t st_next;

  // Address decode of the core access
  logic        hit_index;
  logic        hit_window;
  logic        index_write;
  logic        window_write;
  logic        index_read;
  logic        window_read;

  // Array write port, shared by both paths
  logic        prog_write;
  logic        core_cfg_write;
  logic        mem_write;
  logic [6:0]  mem_addr;
  logic [7:0]  mem_wdata;

  // Array read side
  logic [6:0]  sel_index;
  logic [7:0]  sel_byte;
  logic [7:0]  read_mux;
  logic [7:0]  lower_byte;
  logic [7:0]  upper_byte;
  hw_ctrl_t    ctrl_decoded;

  // Controls sit at erased defaults while reset is held, so a fresh part starts safe
  localparam hw_ctrl_t ctrl_erased = '{
    watchdog_reset_allow:      1'b1,
    data_flash_size_sel:       dflash_none,
    data_flash_reserved:       1'b0,
    digital_brownout_level:    level_2v5,
    analog_brownout_level:     level_2v5,
    analog_brownout_reset_en:  1'b0,
    digital_brownout_reset_en: 1'b0,
    port_zero_ext_bus:         1'b0,
    port_two_ext_bus:          1'b0,
    p36_p37_strobes:           1'b0
  };

  localparam bank_state_t state_reset = '{
    config_byte_index_reg:  `INDEX_RESET,
    config_byte_window_reg: `WINDOW_RESET,
    rdata_reg:              8'h00,
    rvalid_reg:             1'b0,
    ctrl_reg:               ctrl_erased
  };

  // Shared by both supply monitors, which use the same threshold codes
  function automatic brownout_level_t level_of(
    input logic [1:0] code
  );
    brownout_level_t lvl;

    case (code)
      2'b00:
      begin
        lvl = level_4v5;
      end
      2'b01:
      begin
        lvl = level_4v2;
      end
      2'b10:
      begin
        lvl = level_2v7;
      end
      default:
      begin
        lvl = level_2v5;
      end
    endcase
    return lvl;
  endfunction

  // Reserved code 000 is passed through but flagged so users can catch it
  function automatic dflash_size_t flash_size_of(
    input logic [2:0] code
  );
    dflash_size_t sz;

    case (code)
      3'b000:
      begin
        sz = dflash_reserved;
      end
      3'b001:
      begin
        sz = dflash_32k;
      end
      3'b010:
      begin
        sz = dflash_16k;
      end
      3'b011:
      begin
        sz = dflash_8k;
      end
      3'b100:
      begin
        sz = dflash_4k;
      end
      3'b101:
      begin
        sz = dflash_2k;
      end
      3'b110:
      begin
        sz = dflash_1k;
      end
      default:
      begin
        sz = dflash_none;
      end
    endcase
    return sz;
  endfunction

  // Turns the two hardware bytes into the control levels the chip acts on
  function automatic hw_ctrl_t decode_ctrl(
    input logic [7:0] upper,
    input logic [7:0] lower
  );
    hw_ctrl_t c;

    c.watchdog_reset_allow = lower[`LOWER_WDOG_BIT];
    c.data_flash_size_sel =
      flash_size_of(lower[`LOWER_DFS_MSB:0]);
    c.data_flash_reserved =
      (lower[`LOWER_DFS_MSB:0] == dflash_reserved);
    c.digital_brownout_level =
      level_of(upper[`UPPER_DBL_MSB:`UPPER_DBL_LSB]);
    c.analog_brownout_level =
      level_of(upper[`UPPER_ABL_MSB:`UPPER_ABL_LSB]);
    // The off bits read as enables, so the active sense is flipped here
    c.analog_brownout_reset_en = !upper[`UPPER_AOFF_BIT];
    c.digital_brownout_reset_en = !upper[`UPPER_DOFF_BIT];
    c.port_zero_ext_bus = !upper[`UPPER_P0_BIT];
    c.port_two_ext_bus = !upper[`UPPER_P23_BIT];
    // Either bus mode takes over P3.6/P3.7 as write/read strobes
    c.p36_p37_strobes =
      !upper[`UPPER_P0_BIT] || !upper[`UPPER_P23_BIT];
    return c;
  endfunction

  // Core address decode
  always_comb
  begin
    hit_index  = 1'b0;
    hit_window = 1'b0;
    if (sfr_req.addr == `SFR_CONFIG_INDEX)
    begin
      hit_index = 1'b1;
    end
    else if (sfr_req.addr == `SFR_CONFIG_WINDOW)
    begin
      hit_window = 1'b1;
    end
    else
    begin
      hit_index  = 1'b0;
      hit_window = 1'b0;
    end
  end

  assign index_write  = sfr_req.wr && hit_index;
  assign index_read   = sfr_req.rd && hit_index;
  assign window_read  = sfr_req.rd && hit_window;
  // User mode leaves the window write on the floor
  assign window_write = sfr_req.wr && hit_window && !user_application_mode;

  // Only programming mode may alter the array, whichever path asks
  assign prog_write     = prog_req.wr && !user_application_mode;
  assign core_cfg_write = window_write;

  // Write port select: the programming path wins a same-cycle clash with the core
  always_comb
  begin
    mem_write = 1'b0;
    mem_addr  = 7'h00;
    mem_wdata = 8'h00;
    if (prog_write)
    begin
      mem_write = 1'b1;
      mem_addr  = prog_req.addr;
      mem_wdata = prog_req.wdata;
    end
    else if (core_cfg_write)
    begin
      mem_write = 1'b1;
      mem_addr  = sel_index;
      mem_wdata = sfr_req.wdata;
    end
    else
    begin
      mem_write = 1'b0;
    end
  end

  // Array has no reset on purpose: the bytes model flash contents
  always @(posedge clk)
  begin
    if (mem_write)
    begin
      cfg_mem[mem_addr] <= mem_wdata;
    end
  end

  // Index bit 7 is kept in the register but ignored for the 128-entry select
  assign sel_index  = st_reg.config_byte_index_reg[6:0];
  assign sel_byte   = cfg_mem[sel_index];
  assign lower_byte = cfg_mem[`CFG_LOWER_INDEX];
  assign upper_byte = cfg_mem[`CFG_UPPER_INDEX];

  // Read data select; unmapped addresses read as zero
  always_comb
  begin
    if (index_read)
    begin
      read_mux = st_reg.config_byte_index_reg;
    end
    else if (window_read)
    begin
      read_mux = sel_byte;
    end
    else
    begin
      read_mux = 8'h00;
    end
  end

  // Decode is registered below, so the control outputs come from flip-flops
  always_comb
  begin
    ctrl_decoded = decode_ctrl(upper_byte, lower_byte);
  end

  // Next state
  always_comb
  begin
    st_next = st_reg;
    if (index_write)
    begin
      st_next.config_byte_index_reg = sfr_req.wdata;
    end
    if (window_write)
    begin
      st_next.config_byte_window_reg = sfr_req.wdata;
    end
    if (sfr_req.rd)
    begin
      st_next.rvalid_reg = 1'b1;
      st_next.rdata_reg  = read_mux;
    end
    else
    begin
      st_next.rvalid_reg = 1'b0;
    end
    // Controls follow the array one register stage later
    st_next.ctrl_reg = ctrl_decoded;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Constants only; the array keeps its bytes through reset
      st_reg <= state_reset;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flip-flops
  assign sfr_rdata  = st_reg.rdata_reg;
  assign sfr_rvalid = st_reg.rvalid_reg;
  assign hw_ctrl    = st_reg.ctrl_reg;

endmodule

// >>> bench/hw_config_bank_checker_assertions.sv
module hw_config_bank_checker
  import hw_config_pkg::*;
#(
  parameter int NUM_BYTES = 128
)
(
  // Clock, reset, mode
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       user_application_mode,
  // Buses and decoded controls
  input wire sfr_req_t   sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_rvalid,
  input wire prog_req_t  prog_req,
  input wire hw_ctrl_t   hw_ctrl
);
  wire logic pw    = prog_req.wr && !user_application_mode;
  wire logic up_wr = pw && prog_req.addr == 7'h7e;
  wire logic lo_wr = pw && prog_req.addr == 7'h7f;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_rd_answer: assert property (sfr_req.rd |=> sfr_rvalid)
    else $error("read not answered");
  chk_no_stray: assert property (!sfr_req.rd |=> !sfr_rvalid)
    else $error("stray read valid");
  chk_other_zero: assert property (sfr_req.rd && !(sfr_req.addr inside {8'h93, 8'h94})
    |=> sfr_rdata == 8'h00) else $error("foreign address read not zero");
  chk_lower_fields: assert property (lo_wr |=> ##1
    {hw_ctrl.watchdog_reset_allow, hw_ctrl.data_flash_size_sel} == $past(prog_req.wdata[3:0], 2))
    else $error("lower byte decode wrong");
  chk_level_fields: assert property (up_wr |=> ##1
    {hw_ctrl.digital_brownout_level, hw_ctrl.analog_brownout_level} == $past(prog_req.wdata[7:4], 2))
    else $error("brownout level decode wrong");
  chk_enable_bits: assert property (up_wr |=> ##1 {hw_ctrl.analog_brownout_reset_en,
    hw_ctrl.digital_brownout_reset_en, hw_ctrl.port_zero_ext_bus, hw_ctrl.port_two_ext_bus}
    == ~$past(prog_req.wdata[3:0], 2)) else $error("enable bit decode wrong");
  chk_strobe_use: assert property (hw_ctrl.p36_p37_strobes ==
    (hw_ctrl.port_zero_ext_bus || hw_ctrl.port_two_ext_bus)) else $error("strobe select wrong");
  // User mode must never move the decoded controls
  chk_user_frozen: assert property (user_application_mode && $past(user_application_mode) &&
    $past(user_application_mode, 2) && $past(rst_b, 2) |-> $stable(hw_ctrl)) else $error("ctrl moved");
endmodule

bind hw_config_byte_bank hw_config_bank_checker #(.NUM_BYTES(NUM_BYTES)) i_chk (.clk(clk),
  .rst_b(rst_b), .user_application_mode(user_application_mode), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .prog_req(prog_req), .hw_ctrl(hw_ctrl));

// >>> bench/hw_config_byte_bank_test.sv
module hw_config_byte_bank_test import hw_config_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0;
  logic       rst_b = 0;
  logic       user_application_mode = 0;
  sfr_req_t   sfr_req = '0;
  prog_req_t  prog_req = '0;
  logic [7:0] sfr_rdata, up, lo;
  logic       sfr_rvalid;
  hw_ctrl_t   hw_ctrl;
  int         n_fail = 0, tests_run = 0, seed = 33;
  always #50 clk = ~clk;
  hw_config_byte_bank i_dut (.clk(clk), .rst_b(rst_b), .user_application_mode(user_application_mode),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .prog_req(prog_req),
    .hw_ctrl(hw_ctrl));
  function automatic hw_ctrl_t ctrl_of(logic [7:0] u, logic [7:0] l);
    return {l[3], l[2:0], l[2:0] == 3'h0, u[7:4], ~u[3:0], ~(u[1] & u[0])};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Each driver sets both buses once, so back-to-back calls never double-assign
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic idle(int n);
    sfr_req = '0;
    prog_req = '0;
    tick(n);
  endtask
  task automatic prog(logic [6:0] a, logic [7:0] v);
    prog_req = '{1'b1, a, v};
    sfr_req = '0;
    tick(1);
  endtask
  task automatic sfr(logic w, logic [7:0] a, logic [7:0] v);
    sfr_req = '{w, !w, a, v};
    prog_req = '0;
    tick(1);
    if (!w) chk(16'(sfr_rvalid), 16'h0001);
  endtask
  task automatic peek(logic [7:0] idx, logic [7:0] exp);
    sfr(1, 8'h93, idx);
    sfr(0, 8'h94, 8'h00);
    chk(16'(sfr_rdata), 16'(exp));
  endtask
  initial
  begin
    tick(8);
    rst_b = 1;
    idle(2);
    chk(16'(hw_ctrl), 16'(ctrl_of(8'hff, 8'hff)));
    sfr(0, 8'h94, 8'h00);
    chk(16'(sfr_rdata), 16'h00ff);
    sfr(0, 8'h95, 8'h00);
    chk(16'(sfr_rdata), 16'h0000);
    for (int i = 0; i < 12; i++)
    begin
      up = 8'($random(seed));
      lo = 8'($random(seed));
      lo[2:0] = i[2:0];
      up[7:4] = {i[1:0], ~i[1:0]};
      user_application_mode = 0;
      prog(7'h7e, up);
      prog(7'h7f, lo);
      prog(7'(i), up ^ lo);
      idle(2);
      chk(16'(hw_ctrl), 16'(ctrl_of(up, lo)));
      peek(8'h7e, up);
      peek(8'h7f, lo);
      peek(8'(i), up ^ lo);
      user_application_mode = 1;
      prog(7'h7e, ~up);
      sfr(1, 8'h94, ~lo);
      idle(2);
      chk(16'(hw_ctrl), 16'(ctrl_of(up, lo)));
      peek(8'(i), up ^ lo);
    end
    user_application_mode = 0;
    sfr(1, 8'h93, 8'h05);
    sfr(1, 8'h94, 8'h5a);
    peek(8'h05, 8'h5a);
    rst_b = 0;
    idle(2);
    rst_b = 1;
    idle(2);
    chk(16'(hw_ctrl), 16'(ctrl_of(up, lo)));
    sfr(0, 8'h93, 8'h00);
    chk(16'(sfr_rdata), 16'h0000);
    wrap_up();
  end
  initial
  begin
    #400_000;
    n_fail++;
    wrap_up();
  end
endmodule
